// ### logic/cmbf_pkg.sv
// Behaviour
// RULE1 - fill table until maximum; never displace entries (a provisioned address still evicts a learned customer when no room remains)
// RULE2 - table maximum configurable, never below one
// RULE3 - provisioned addresses loaded without any learning
// RULE4 - provisioned entry beats learned entry
// RULE5 - entries never age out
// RULE6 - reset clears every table entry
// RULE7 - each accepted frame decided exactly once
// RULE8 - frame not delivered in time is dropped
// RULE9 - frames leave in arrival order
// RULE10 - cable side unknown destination is dropped
// RULE11 - cable broadcast passes unless source is customer
// RULE12 - cable multicast needs policy and group permit
// RULE13 - ethernet unknown destination goes to cable
// RULE14 - ethernet broadcast goes to cable
// RULE15 - ethernet multicast follows operator filter setting
// RULE16 - ethernet frame from non-customer source dropped
// RULE17 - single user: second source never forwarded
// RULE18 - non-customer sources learned, filter local traffic
// RULE19 - single user: customer to local dropped
// RULE20 - selectable discard of spanning tree units
// RULE21 - ip always forwarded; single protocol restriction
// RULE22 - short upstream frames allowed, no padding
// RULE23 - classify source and destination before deciding
package cmbf_pkg;
  // table geometry
  localparam int TBL_DEPTH = 16,
    TBL_IDX_W = 4,
    MAC_W = 48,
    MAX_W = TBL_IDX_W + 1;
  localparam logic [MAX_W-1:0] MAX_RESET = 5'h10,
    MAX_MIN = 5'h01;

  // kind of a table entry
  typedef enum logic [1:0] {
    KIND_NONE = 2'h0,
    KIND_PROV = 2'h1,
    KIND_LEARN = 2'h2,
    KIND_LOCAL = 2'h3
  } cmbf_kind_type;

  // register offsets on the plain port
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00,
    REG_MAX = 8'h04,
    REG_PROV_LO = 8'h08,
    REG_PROV_HI = 8'h0C,
    REG_STATUS = 8'h10,
    REG_PROTO = 8'h14,
    REG_DROPS = 8'h18;

  // control fields
  localparam int CTRL_W = 4,
    CTRL_BPDU_BIT = 0,
    CTRL_PROTO_BIT = 1,
    CTRL_SINGLE_BIT = 2,
    CTRL_MCAST_BIT = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h9;
  localparam logic [15:0] PROTO_RESET = 16'h0800,
    PROTO_IP = 16'h0800;
  localparam int STAT_BUSY_BIT = 8,
    STAT_FULL_BIT = 9;

  // well known destinations
  localparam logic [MAC_W-1:0] BCAST_MAC = 48'hFFFFFFFFFFFF,
    BPDU_MAC = 48'h0180C2000000;
  localparam int GROUP_BIT = 40;

  // timing
  localparam int CLK_FREQ_KHZ = 40000,
    STALE_TIME_US = 10,
    STALE_CYCLES_INT = STALE_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam logic [15:0] STALE_CYCLES = 16'(STALE_CYCLES_INT);

  // decision reason codes
  localparam logic [3:0] RSN_FWD = 4'h0,
    RSN_BPDU = 4'h1,
    RSN_PROTO = 4'h2,
    RSN_SRC = 4'h3,
    RSN_LOCAL = 4'h4,
    RSN_UNKNOWN = 4'h5,
    RSN_BCAST_SELF = 4'h6,
    RSN_MCAST = 4'h7,
    RSN_STALE = 4'h8;
endpackage

// ### logic/cmbf_addr_table.sv
`timescale 1ns/1ps
module cmbf_addr_table #(
  parameter int DEPTH = cmbf_pkg::TBL_DEPTH,
  parameter int IDX_W = cmbf_pkg::TBL_IDX_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire cmbf_pkg::cmbf_kind_type wr_kind,
  input wire logic [cmbf_pkg::MAC_W-1:0] wr_mac,
  // query addresses
  input wire logic [cmbf_pkg::MAC_W-1:0] src_mac,
  input wire logic [cmbf_pkg::MAC_W-1:0] dst_mac,
  // registered lookup results
  output cmbf_pkg::cmbf_kind_type src_kind,
  output logic [IDX_W-1:0] src_idx,
  output cmbf_pkg::cmbf_kind_type dst_kind,
  output logic free_found,
  output logic [IDX_W-1:0] free_idx,
  output logic lcust_found,
  output logic [IDX_W-1:0] lcust_idx,
  output logic [IDX_W:0] cust_count
);
  import cmbf_pkg::*;

  // whole table plus registered answers
  typedef struct packed {
    logic [DEPTH-1:0][1:0] kind;
    logic [DEPTH-1:0][MAC_W-1:0] mac;
    cmbf_kind_type src_kind;
    logic [IDX_W-1:0] src_idx;
    cmbf_kind_type dst_kind;
    logic free_found;
    logic [IDX_W-1:0] free_idx;
    logic lcust_found;
    logic [IDX_W-1:0] lcust_idx;
    logic [IDX_W:0] cust_count;
  } cmbf_tbl_state_type;

  cmbf_tbl_state_type s;
  cmbf_tbl_state_type next_s;
  logic [IDX_W+1:0] src_hit;
  logic [IDX_W+1:0] dst_hit;

  // lowest matching valid entry: kind and index
  function automatic logic [IDX_W+1:0] tbl_find(
    input logic [MAC_W-1:0] key,
    input logic [DEPTH-1:0][1:0] kinds,
    input logic [DEPTH-1:0][MAC_W-1:0] macs
  );
    logic [IDX_W+1:0] res;
    res = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (kinds[i] != KIND_NONE && macs[i] == key) begin
        res = {kinds[i], IDX_W'(i)};
      end
    end
    return res;
  endfunction

  // table update and parallel classification
  always_comb begin
    next_s = s;
    src_hit = tbl_find(src_mac, s.kind, s.mac);
    dst_hit = tbl_find(dst_mac, s.kind, s.mac);
    // entries change only by explicit write, never by age
    if (wr_en) begin // RULE5
      next_s.kind[wr_idx] = wr_kind;
      next_s.mac[wr_idx] = wr_mac;
    end
    // classify source and destination
    next_s.src_kind = cmbf_kind_type'(src_hit[IDX_W+1:IDX_W]); // RULE23
    next_s.src_idx = src_hit[IDX_W-1:0];
    next_s.dst_kind = cmbf_kind_type'(dst_hit[IDX_W+1:IDX_W]); // RULE23
    next_s.free_found = 1'b0;
    next_s.free_idx = '0;
    next_s.lcust_found = 1'b0;
    next_s.lcust_idx = '0;
    next_s.cust_count = '0;
    // scan for free slot, learned customer, customer count
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (s.kind[i] == KIND_NONE) begin
        next_s.free_found = 1'b1;
        next_s.free_idx = IDX_W'(i);
      end
      if (s.kind[i] == KIND_LEARN) begin
        next_s.lcust_found = 1'b1;
        next_s.lcust_idx = IDX_W'(i);
      end
      if (s.kind[i] == KIND_PROV || s.kind[i] == KIND_LEARN) begin
        next_s.cust_count = next_s.cust_count + (IDX_W + 1)'(1);
      end
    end
  end

  // reset empties the whole table
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0; // RULE6
    end else begin
      s <= next_s;
    end
  end

  // answers straight from the register
  assign src_kind = s.src_kind;
  assign src_idx = s.src_idx;
  assign dst_kind = s.dst_kind;
  assign free_found = s.free_found;
  assign free_idx = s.free_idx;
  assign lcust_found = s.lcust_found;
  assign lcust_idx = s.lcust_idx;
  assign cust_count = s.cust_count;
endmodule

// ### logic/cmbf_bridge_filter.sv
`timescale 1ns/1ps
module cmbf_bridge_filter #(
  parameter int DEPTH = cmbf_pkg::TBL_DEPTH,
  parameter int IDX_W = cmbf_pkg::TBL_IDX_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [cmbf_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // frame header offered for a decision
  input wire logic hdr_valid,
  output logic hdr_ready,
  input wire logic hdr_to_eth,
  input wire logic [cmbf_pkg::MAC_W-1:0] hdr_dst,
  input wire logic [cmbf_pkg::MAC_W-1:0] hdr_src,
  input wire logic [15:0] hdr_ethertype,
  input wire logic hdr_policy_permit,
  input wire logic hdr_group_permit,
  // decision toward the frame mover
  output logic dec_valid,
  input wire logic dec_ready,
  output logic dec_forward,
  output logic [3:0] dec_reason,
  output logic dec_stale
);
  import cmbf_pkg::*;

  // one-hot sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_QUERY = 4'b0010,
    ST_DECIDE = 4'b0100,
    ST_EMIT = 4'b1000
  } cmbf_state_type;

  // all state of the filter
  typedef struct packed {
    cmbf_state_type fsm;
    logic hdr_ready;
    logic is_prov;
    logic to_eth;
    logic [MAC_W-1:0] dst;
    logic [MAC_W-1:0] src;
    logic [15:0] etype;
    logic policy;
    logic group;
    logic [CTRL_W-1:0] ctrl;
    logic [MAX_W-1:0] max;
    logic [15:0] proto;
    logic [31:0] prov_lo;
    logic prov_pending;
    logic [MAC_W-1:0] prov_mac;
    logic [31:0] rdata;
    logic dec_valid;
    logic dec_forward;
    logic [3:0] dec_reason;
    logic dec_stale;
    logic [15:0] wait_cnt;
    logic [15:0] drops;
    logic wr_en;
    logic [IDX_W-1:0] wr_idx;
    cmbf_kind_type wr_kind;
    logic [MAC_W-1:0] wr_mac;
  } cmbf_filter_state_type;

  cmbf_filter_state_type s;
  cmbf_filter_state_type next_s;

  // table answers, valid in the decide state
  cmbf_kind_type t_src_kind;
  logic [IDX_W-1:0] t_src_idx;
  cmbf_kind_type t_dst_kind;
  logic t_free_found;
  logic [IDX_W-1:0] t_free_idx;
  logic t_lcust_found;
  logic [IDX_W-1:0] t_lcust_idx;
  logic [IDX_W:0] t_cust_count;

  // decision helpers
  logic [MAX_W-1:0] eff_max;
  logic room;
  logic is_bcast;
  logic is_mcast;
  logic is_bpdu;
  logic src_cust;
  logic src_new_cust;
  logic src_ok;
  logic fwd;
  logic [3:0] rsn;
  logic [MAX_W-1:0] max_wr;

  // true for a customer entry, provisioned or learned
  function automatic logic is_cust(input cmbf_kind_type k);
    return (k == KIND_PROV) || (k == KIND_LEARN);
  endfunction

  // address table
  cmbf_addr_table #(
    .DEPTH(DEPTH),
    .IDX_W(IDX_W)
  ) u_table (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(s.wr_en),
    .wr_idx(s.wr_idx),
    .wr_kind(s.wr_kind),
    .wr_mac(s.wr_mac),
    .src_mac(s.src),
    .dst_mac(s.dst),
    .src_kind(t_src_kind),
    .src_idx(t_src_idx),
    .dst_kind(t_dst_kind),
    .free_found(t_free_found),
    .free_idx(t_free_idx),
    .lcust_found(t_lcust_found),
    .lcust_idx(t_lcust_idx),
    .cust_count(t_cust_count)
  );

  // single user shrinks the customer limit to one entry
  assign eff_max = s.ctrl[CTRL_SINGLE_BIT] ? MAX_MIN : s.max; // RULE17
  // customer slots remain below the limit
  assign room = ({1'b0, t_cust_count} < {1'b0, eff_max}) && t_free_found; // RULE1
  // address class of the held frame
  assign is_bcast = (s.dst == BCAST_MAC);
  assign is_mcast = s.dst[GROUP_BIT] && !is_bcast;
  assign is_bpdu = (s.dst == BPDU_MAC);
  // source class
  assign src_cust = is_cust(t_src_kind);
  assign src_new_cust = (t_src_kind == KIND_NONE) && room;
  assign src_ok = src_cust || src_new_cust;
  // written maximum held between one and the table size
  assign max_wr = (reg_wdata[MAX_W-1:0] == '0) ? MAX_MIN :
                  (reg_wdata[MAX_W-1:0] > MAX_RESET) ? MAX_RESET : reg_wdata[MAX_W-1:0];

  // per frame forward decision from the classified addresses
  always_comb begin
    fwd = 1'b1;
    rsn = RSN_FWD;
    if (is_bpdu && s.ctrl[CTRL_BPDU_BIT]) begin
      // spanning tree units discarded when selected
      fwd = 1'b0; // RULE20
      rsn = RSN_BPDU;
    end else if (s.ctrl[CTRL_PROTO_BIT] && s.etype != s.proto && s.etype != PROTO_IP) begin
      // restricted to one protocol, ip always passes
      fwd = 1'b0; // RULE21
      rsn = RSN_PROTO;
    end else if (!s.to_eth) begin
      // ethernet to cable
      if (!src_ok) begin
        // unsupported or second source is held back
        fwd = 1'b0; // RULE16 RULE17
        rsn = RSN_SRC;
      end else if (!is_bcast && !is_mcast && t_dst_kind != KIND_NONE) begin
        // destination lives on the ethernet side
        fwd = 1'b0; // RULE18 RULE19
        rsn = RSN_LOCAL;
      end else if (is_bcast) begin
        fwd = 1'b1; // RULE14
      end else if (is_mcast) begin
        // operator multicast filter setting
        fwd = s.ctrl[CTRL_MCAST_BIT]; // RULE15
        rsn = s.ctrl[CTRL_MCAST_BIT] ? RSN_FWD : RSN_MCAST;
      end else begin
        // unknown destination goes upstream, any length passes unpadded
        fwd = 1'b1; // RULE13 RULE22
      end
    end else begin
      // cable to ethernet
      if (is_bcast) begin
        // own customers' broadcasts are not looped back
        fwd = !src_cust; // RULE11
        rsn = src_cust ? RSN_BCAST_SELF : RSN_FWD;
      end else if (is_mcast) begin
        // both policy and group tracking must permit
        fwd = s.policy && s.group; // RULE12
        rsn = (s.policy && s.group) ? RSN_FWD : RSN_MCAST;
      end else if (t_dst_kind == KIND_NONE) begin
        fwd = 1'b0; // RULE10
        rsn = RSN_UNKNOWN;
      end
    end
  end

  // next state of the whole filter
  always_comb begin
    next_s = s;
    next_s.rdata = '0;
    next_s.dec_stale = 1'b0;
    next_s.wr_en = 1'b0;
    // frames pass one at a time, strictly in arrival order
    unique case (s.fsm) // RULE9
      ST_IDLE: begin
        if (s.prov_pending) begin
          // provisioning goes ahead of traffic
          next_s.prov_pending = 1'b0;
          next_s.is_prov = 1'b1;
          next_s.src = s.prov_mac;
          next_s.dst = s.prov_mac;
          next_s.fsm = ST_QUERY;
        end else if (hdr_valid && s.hdr_ready) begin
          // take the header
          next_s.is_prov = 1'b0;
          next_s.to_eth = hdr_to_eth;
          next_s.dst = hdr_dst;
          next_s.src = hdr_src;
          next_s.etype = hdr_ethertype;
          next_s.policy = hdr_policy_permit;
          next_s.group = hdr_group_permit;
          next_s.fsm = ST_QUERY;
        end
      end
      ST_QUERY: begin
        // table registers its classification
        next_s.fsm = ST_DECIDE; // RULE23
      end
      ST_DECIDE: begin
        next_s.wr_mac = s.src;
        if (s.is_prov) begin
          next_s.fsm = ST_IDLE;
          next_s.wr_kind = KIND_PROV;
          if (t_src_kind == KIND_LEARN) begin
            // already learned, promote in place
            next_s.wr_en = 1'b1; // RULE3
            next_s.wr_idx = t_src_idx;
          end else if (t_src_kind != KIND_PROV && room) begin
            // free customer slot
            next_s.wr_en = 1'b1; // RULE3
            next_s.wr_idx = (t_src_kind == KIND_LOCAL) ? t_src_idx : t_free_idx;
          end else if (t_src_kind != KIND_PROV && t_lcust_found) begin
            // no room left: evict a learned customer
            next_s.wr_en = 1'b1; // RULE4
            next_s.wr_idx = t_lcust_idx;
          end
        end else begin
          // learn unseen ethernet sources, never displacing
          if (!s.to_eth && t_src_kind == KIND_NONE && t_free_found) begin // RULE1
            next_s.wr_en = 1'b1;
            next_s.wr_idx = t_free_idx;
            // beyond the limit the source is only a local station
            next_s.wr_kind = src_new_cust ? KIND_LEARN : KIND_LOCAL; // RULE18
          end
          // exactly one decision per frame
          next_s.dec_valid = 1'b1; // RULE7
          next_s.dec_forward = fwd;
          next_s.dec_reason = rsn;
          next_s.wait_cnt = '0;
          if (!fwd) begin
            next_s.drops = s.drops + 16'h0001;
          end
          next_s.fsm = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (dec_ready) begin
          // decision taken once
          next_s.dec_valid = 1'b0; // RULE7
          next_s.fsm = ST_IDLE;
        end else if (s.wait_cnt == STALE_CYCLES - 16'h0001) begin
          // too late: withdraw and count the drop
          next_s.dec_valid = 1'b0; // RULE8
          next_s.dec_stale = 1'b1;
          next_s.dec_reason = RSN_STALE;
          next_s.drops = s.drops + 16'h0001;
          next_s.fsm = ST_IDLE;
        end else begin
          next_s.wait_cnt = s.wait_cnt + 16'h0001;
        end
      end
    endcase
    // register writes, after the sequencer so a new load wins
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: next_s.ctrl = reg_wdata[CTRL_W-1:0];
        REG_MAX: next_s.max = max_wr; // RULE2
        REG_PROV_LO: next_s.prov_lo = reg_wdata;
        REG_PROV_HI: begin
          // upper half completes a provisioned address
          next_s.prov_mac = {reg_wdata[15:0], s.prov_lo}; // RULE3
          next_s.prov_pending = 1'b1;
        end
        REG_PROTO: next_s.proto = reg_wdata[15:0];
        default: ;
      endcase
    end
    // register reads answer in the following cycle only
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: next_s.rdata = {{(32 - CTRL_W){1'b0}}, s.ctrl};
        REG_MAX: next_s.rdata = {{(32 - MAX_W){1'b0}}, s.max};
        REG_PROV_LO: next_s.rdata = s.prov_lo;
        REG_PROV_HI: next_s.rdata = {16'h0000, s.prov_mac[MAC_W-1:32]};
        REG_STATUS: begin
          next_s.rdata[IDX_W:0] = t_cust_count;
          next_s.rdata[STAT_BUSY_BIT] = (s.fsm != ST_IDLE) || s.prov_pending;
          next_s.rdata[STAT_FULL_BIT] = ({1'b0, t_cust_count} >= {1'b0, eff_max});
        end
        REG_PROTO: next_s.rdata = {16'h0000, s.proto};
        REG_DROPS: next_s.rdata = {16'h0000, s.drops};
        default: next_s.rdata = '0;
      endcase
    end
    // headers are taken only when idle with no provisioning waiting
    next_s.hdr_ready = (next_s.fsm == ST_IDLE) && !next_s.prov_pending;
  end

  // state register; reset restores every setting
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.fsm <= ST_IDLE;
      s.hdr_ready <= 1'b1;
      s.ctrl <= CTRL_RESET;
      s.max <= MAX_RESET;
      s.proto <= PROTO_RESET;
      s.wr_kind <= KIND_NONE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = s.rdata;
  assign hdr_ready = s.hdr_ready;
  assign dec_valid = s.dec_valid;
  assign dec_forward = s.dec_forward;
  assign dec_reason = s.dec_reason;
  assign dec_stale = s.dec_stale;
endmodule

// ### tb/cmbf_bridge_filter_properties.sv
`timescale 1ns/1ps
module cmbf_bridge_filter_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // header handshake
  input wire logic hdr_valid,
  input wire logic hdr_ready,
  // decision handshake
  input wire logic dec_valid,
  input wire logic dec_ready,
  input wire logic dec_forward,
  input wire logic [3:0] dec_reason,
  input wire logic dec_stale
);
  import cmbf_pkg::*;
  // cycles an offered decision has gone unanswered
  logic [9:0] wait_cnt;
  logic [9:0] next_wait_cnt;
  // count while offered and not taken
  always_comb begin
    next_wait_cnt = (dec_valid && !dec_ready) ? wait_cnt + 10'h001 : 10'h000;
  end
  // register the count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 10'h000;
    end else begin
      wait_cnt <= next_wait_cnt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a header taken, then lookup, decide and offer
  sequence s_take;
    hdr_valid && hdr_ready;
  endsequence
  sequence s_answer;
    !dec_valid ##1 !dec_valid ##1 dec_valid;
  endsequence
  dec_latency_a: assert property (s_take |=> s_answer)
    else $error("decision late");
  one_frame_a: assert property (dec_valid |-> !hdr_ready)
    else $error("header taken while busy");
  dec_hold_a: assert property (dec_valid && !dec_ready |=> dec_stale ||
    (dec_valid && $stable(dec_forward) && $stable(dec_reason)))
    else $error("decision changed");
  dec_release_a: assert property (dec_valid && dec_ready |=> !dec_valid && !dec_stale)
    else $error("decision not released");
  stale_reason_a: assert property (dec_stale |-> !dec_valid && dec_reason == RSN_STALE)
    else $error("stale reason wrong");
  stale_pulse_a: assert property (dec_stale |=> !dec_stale)
    else $error("stale flag too long");
  stale_time_a: assert property (dec_stale |-> wait_cnt == 10'(STALE_CYCLES))
    else $error("stale time wrong");
  fwd_reason_a: assert property (dec_valid |-> dec_forward == (dec_reason == RSN_FWD))
    else $error("forward and reason differ");
endmodule

bind cmbf_bridge_filter cmbf_bridge_filter_props i_props (.sys_clk, .rst, .hdr_valid,
  .hdr_ready, .dec_valid, .dec_ready, .dec_forward, .dec_reason, .dec_stale);

// ### tb/cmbf_mover_model.sv
`timescale 1ns/1ps
module cmbf_mover_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // decision handshake
  input wire logic dec_valid,
  output logic dec_ready,
  input wire logic dec_forward,
  input wire logic [3:0] dec_reason,
  // pacing and what was taken
  input wire logic [9:0] wait_cycles,
  output logic got_fwd,
  output logic [3:0] got_rsn,
  output logic [7:0] got_cnt
);
  // cycles the current decision has waited
  logic [9:0] age;
  // take a decision after a chosen delay, one-cycle ready pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dec_ready <= 1'h0;
      got_fwd <= 1'h0;
      got_rsn <= 4'h0;
      got_cnt <= 8'h00;
      age <= 10'h000;
    end else begin
      dec_ready <= 1'h0;
      if (dec_valid && dec_ready) begin
        got_fwd <= dec_forward;
        got_rsn <= dec_reason;
        got_cnt <= got_cnt + 8'h01;
        age <= 10'h000;
      end else if (dec_valid) begin
        // slow consumer lets the decision age
        if (age >= wait_cycles) begin
          dec_ready <= 1'h1;
        end else begin
          age <= age + 10'h001;
        end
      end else begin
        age <= 10'h000;
      end
    end
  end
endmodule

// ### tb/test_cmbf_bridge_filter.sv
`timescale 1ns/1ps
module test_cmbf_bridge_filter;
  import cmbf_pkg::*;
  // stations: customers, local, unknown, provisioned, group
  localparam logic [47:0] MA = 48'h02000000000A,
    MB = 48'h02000000000B,
    MC = 48'h02000000000C,
    MD = 48'h02000000000D,
    MP = 48'h0200000000E5,
    MM = 48'h01005E000001;
  // clock, reset, register port
  logic sys_clk, rst, reg_wr, reg_rd;
  logic [REG_AW-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  // header and decision
  logic hdr_valid, hdr_ready, hdr_to_eth, hdr_policy_permit, hdr_group_permit;
  logic [47:0] hdr_dst, hdr_src;
  logic [15:0] hdr_ethertype;
  logic dec_valid, dec_ready, dec_forward, dec_stale, got_fwd;
  logic [3:0] dec_reason, got_rsn;
  logic [7:0] got_cnt;
  logic [9:0] wait_cycles;
  int num_errors = 0;
  int tests_run = 0;

  cmbf_bridge_filter i_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .hdr_valid, .hdr_ready, .hdr_to_eth, .hdr_dst, .hdr_src, .hdr_ethertype,
    .hdr_policy_permit, .hdr_group_permit, .dec_valid, .dec_ready, .dec_forward,
    .dec_reason, .dec_stale);
  cmbf_mover_model i_mover (.sys_clk, .rst, .dec_valid, .dec_ready, .dec_forward,
    .dec_reason, .wait_cycles, .got_fwd, .got_rsn, .got_cnt);

  // 40 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // a wait that ran out of patience
  task automatic tmo(input string what);
    num_errors++;
    $display("CHECK FAILED %s expected handshake seen timeout", what);
    end_of_test();
  endtask
  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [REG_AW-1:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    check(what, reg_rdata, e);
  endtask
  // offer one header and hold it until taken
  task automatic offer(input logic te, input logic [47:0] d, input logic [47:0] s,
                       input logic [15:0] et, input logic [1:0] pg);
    int n;
    @(posedge sys_clk);
    hdr_valid <= 1'h1;
    hdr_to_eth <= te;
    hdr_dst <= d;
    hdr_src <= s;
    hdr_ethertype <= et;
    {hdr_policy_permit, hdr_group_permit} <= pg;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hdr_ready !== 1'h1 && n < 40);
    hdr_valid <= 1'h0;
    if (n >= 40) tmo("hdr_ready");
  endtask
  // one frame through, decision judged once taken
  task automatic fr(input logic te, input logic [47:0] d, input logic [47:0] s,
                    input logic [15:0] et, input logic [1:0] pg, input logic fw,
                    input logic [3:0] rs);
    logic [7:0] c0;
    int n;
    c0 = got_cnt;
    offer(te, d, s, et, pg);
    n = 0;
    while (got_cnt === c0 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 500) tmo("decision");
    repeat (3) @(posedge sys_clk);
    check("forward", {31'h0, got_fwd}, {31'h0, fw});
    check("reason", {28'h0, got_rsn}, {28'h0, rs});
    check("decided once", {24'h0, got_cnt}, {24'h0, c0 + 8'h01});
  endtask

  task automatic t_reset();
    rd_chk("ctrl", REG_CTRL, {28'h0, CTRL_RESET});
    rd_chk("proto", REG_PROTO, {16'h0, PROTO_RESET});
    rd_chk("status", REG_STATUS, 32'h0);
    rd_chk("unmapped", 8'h1C, 32'h0);
    rd_chk("max", REG_MAX, {27'h0, MAX_RESET});
    wr(REG_MAX, 32'h0);
    rd_chk("max floor", REG_MAX, 32'h1);
    wr(REG_MAX, 32'h14);
    rd_chk("max ceiling", REG_MAX, 32'h10);
    $display("done reset values");
  endtask
  task automatic t_learn();
    wr(REG_MAX, 32'h2);
    fr(1'h0, MD, MA, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    fr(1'h0, MD, MB, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    fr(1'h0, MD, MC, PROTO_IP, 2'h0, 1'h0, RSN_SRC);
    rd_chk("status full", REG_STATUS, 32'h202);
    fr(1'h0, MC, MA, PROTO_IP, 2'h0, 1'h0, RSN_LOCAL);
    $display("done learning");
  endtask
  task automatic t_cable();
    fr(1'h1, MD, MC, PROTO_IP, 2'h3, 1'h0, RSN_UNKNOWN);
    fr(1'h1, MA, MD, PROTO_IP, 2'h3, 1'h1, RSN_FWD);
    fr(1'h1, BCAST_MAC, MA, PROTO_IP, 2'h0, 1'h0, RSN_BCAST_SELF);
    fr(1'h1, BCAST_MAC, MD, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    for (int i = 0; i < 4; i++) begin
      fr(1'h1, MM, MD, PROTO_IP, 2'(i), i == 3, (i == 3) ? RSN_FWD : RSN_MCAST);
    end
    $display("done cable side");
  endtask
  task automatic t_eth();
    fr(1'h0, BCAST_MAC, MA, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    fr(1'h0, MM, MA, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    fr(1'h0, BPDU_MAC, MA, PROTO_IP, 2'h0, 1'h0, RSN_BPDU);
    wr(REG_CTRL, 32'h8);
    fr(1'h0, BPDU_MAC, MA, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    wr(REG_CTRL, 32'h1);
    fr(1'h0, MM, MA, PROTO_IP, 2'h0, 1'h0, RSN_MCAST);
    wr(REG_CTRL, 32'hB);
    wr(REG_PROTO, 32'h806);
    fr(1'h0, MD, MA, 16'h0806, 2'h0, 1'h1, RSN_FWD);
    fr(1'h0, MD, MA, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    fr(1'h0, MD, MA, 16'h86DD, 2'h0, 1'h0, RSN_PROTO);
    wr(REG_CTRL, 32'h9);
    $display("done ethernet side");
  endtask
  // consumer never answers, decision must be withdrawn
  task automatic t_stale();
    logic [7:0] c0;
    int n;
    c0 = got_cnt;
    wait_cycles <= 10'h3FF;
    offer(1'h0, MD, MA, PROTO_IP, 2'h0);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (dec_stale !== 1'h1 && n < 700);
    if (n >= 700) tmo("stale");
    check("stale reason", {28'h0, dec_reason}, {28'h0, RSN_STALE});
    check("stale not taken", {24'h0, got_cnt}, {24'h0, c0});
    rd_chk("drops", REG_DROPS, 32'hB);
    wait_cycles <= 10'h000;
    $display("done stale");
  endtask
  task automatic prov(input logic [47:0] m);
    wr(REG_PROV_LO, m[31:0]);
    wr(REG_PROV_HI, {16'h0, m[47:32]});
  endtask
  task automatic t_prov();
    prov(MP);
    fr(1'h0, MD, MP, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    rd_chk("status evict", REG_STATUS, 32'h202);
    fr(1'h0, MD, MA, PROTO_IP, 2'h0, 1'h0, RSN_SRC);
    fr(1'h0, MD, MB, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    $display("done provisioning");
  endtask
  // reset in mid-run, then single user
  task automatic t_single();
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    rd_chk("status cleared", REG_STATUS, 32'h0);
    prov(MP);
    fr(1'h0, MD, MP, PROTO_IP, 2'h0, 1'h1, RSN_FWD);
    rd_chk("status one", REG_STATUS, 32'h1);
    wr(REG_CTRL, 32'hD);
    fr(1'h0, MD, MB, PROTO_IP, 2'h0, 1'h0, RSN_SRC);
    fr(1'h0, MB, MP, PROTO_IP, 2'h0, 1'h0, RSN_LOCAL);
    $display("done single user");
  endtask

  // main sequence
  initial begin
    rst = 1'h1;
    {reg_wr, reg_rd, hdr_valid, hdr_to_eth, hdr_policy_permit, hdr_group_permit} = 6'h00;
    {reg_addr, reg_wdata, hdr_dst, hdr_src, hdr_ethertype, wait_cycles} = '0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    t_reset();
    t_learn();
    t_cable();
    t_eth();
    t_stale();
    t_prov();
    t_single();
    end_of_test();
  end
endmodule
